// [logic/clock_gen_pkg.sv]
// shared constants, register map and types of the clock generator and watchdog
package clock_gen_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the apb bus
  localparam logic [7:0] ADDR_WDOG_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WDOG_KEY  = 8'h04;
  localparam logic [7:0] ADDR_SYNTH_CFG = 8'h08;
  localparam logic [7:0] ADDR_CLK_CTRL  = 8'h0C;
  localparam logic [7:0] ADDR_CLK_FLAG  = 8'h10;

  // field positions
  localparam int WD_RATE_LSB = 0;
  localparam int WD_WIN_BIT  = 7;
  localparam int REFERENCE_DIVIDER_FIELD_LSB   = 0;
  localparam int MULTIPLIER_FIELD_LSB    = 8;

  // watchdog restart keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // source edges counted during a clock source change, per clock
  localparam logic [2:0] SW_EDGES = 3'h4;

  // synchronised pin indices
  localparam int PIN_OSC     = 0;
  localparam int PIN_SYNTH   = 1;
  localparam int PIN_FAIL    = 2;
  localparam int PIN_LOCK_IN = 3;
  localparam int PIN_UNL_OUT = 4;
  localparam int PIN_TRK_IN  = 5;
  localparam int PIN_UNT_OUT = 6;
  localparam int PIN_COUNT   = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic monitor_enable;
    logic self_clock_enable;
    logic lock_interrupt_enable;
    logic acq;
    logic auto_mode;
    logic synth_enable;
    logic synth_clock_select;
  } clk_ctrl_t;

  // monitor on, self clock on, acquisition, automatic mode
  localparam clk_ctrl_t CTRL_RESET = 7'h6C;

  typedef struct packed {
    logic lock_irq_flag;
    logic self_clock_mode;
    logic track;
    logic lock;
  } clk_flag_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_OSC  = 3'b010,
    SW_SYN  = 3'b100
  } sw_state_t;

  // watchdog timeout exponent (oscillator cycles = 2**exp) per rate code
  function automatic logic [4:0] wd_exp(input logic [2:0] rate);
    logic [4:0] e;
    e = 5'h0;
    unique case (rate)
      3'h1: e = 5'h0E;
      3'h2: e = 5'h10;
      3'h3: e = 5'h12;
      3'h4: e = 5'h14;
      3'h5: e = 5'h16;
      3'h6: e = 5'h17;
      3'h7: e = 5'h18;
      default: e = 5'h0;
    endcase
    return e;
  endfunction

endpackage

// [logic/clock_gen_watchdog_arm.sv]
// clock generator control: watchdog restart, synthesizer dividers, lock, source switch
//
// Contract
// - restart key register reads zero, writable anytime
// - rate select zero disables, key writes ignored
// - enabled, non-key write resets immediately
// - repeated first or second keys cause no reset
// - windowed: keys only in final quarter
// - reference divider divides oscillator by field+1
// - feedback divider divides synthesizer by 2(field+1)
// - synthesizer selected: bus clock is synthesizer/2
// - tracking bit zero acquiring, one tracking
// - automatic mode: detector switches filter, bit read-only
// - automatic: lock set entering, cleared leaving tolerance
// - lock toggle raises interrupt when enabled
// - manual: acquisition bit one acquires, zero tracks
// - synthesizer stays on while selected
// - source change: 4+4 edges, clocks frozen, cpu halted
// - core clock twice bus clock
// - bus clock drives external clock pin
// - self-clock: synthesizer minimum frequency replaces oscillator
// - monitor fail: self-clock if enabled, else reset
// - monitor enable bit gates clock failure
// - nonzero rate enables watchdog, starts period
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

module clock_gen_watchdog_arm #(
  parameter logic [4:0] WD_EXP_CUT = 5'h0       // shortens watchdog periods by 2**cut
) (
  input  logic        pclk,                     // apb clock, 250 MHz
  input  logic        presetn,                  // async reset, active low
  input  logic        psel,                     // apb select
  input  logic        penable,                  // apb enable
  input  logic        pwrite,                   // apb direction
  input  logic [7:0]  paddr,                    // apb byte address
  input  logic [31:0] pwdata,                   // apb write data
  output logic [31:0] prdata,                   // apb read data
  output logic        pready,                   // apb ready
  output logic        pslverr,                  // apb error on unmapped address
  input  logic        osc_clk_pin,              // oscillator clock, sampled
  input  logic        synth_clk_pin,            // synthesizer clock, sampled
  input  logic        monitor_fail_pin,         // clock monitor fail level
  input  logic        lock_tol_in_pin,          // frequency inside lock tolerance
  input  logic        unlock_tol_out_pin,       // frequency outside unlock tolerance
  input  logic        track_tol_in_pin,         // frequency inside track tolerance
  input  logic        untrack_tol_out_pin,      // frequency outside untrack tolerance
  output logic        ref_tick,                 // reference divider output pulse
  output logic        fb_tick,                  // feedback divider output pulse
  output logic        synth_power_on,           // synthesizer power request
  output logic        filter_acquire,           // loop filter in acquisition
  output logic        self_clock_min_freq_req,  // run vco at minimum frequency
  output logic        monitor_enable_out,       // clock monitor on
  output logic        core_clk,                 // core clock
  output logic        bus_clk,                  // bus clock
  output logic        external_bus_clock_out,   // bus clock on external pin
  output logic        cpu_halt,                 // cpu stopped during switch
  output logic        lock_irq,                 // lock change interrupt request
  output logic        watchdog_reset,           // watchdog reset pulse
  output logic        monitor_reset             // clock monitor reset pulse
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [clock_gen_pkg::PIN_COUNT-1:0] pins;
  logic [clock_gen_pkg::PIN_COUNT-1:0] pin_s1_r;
  logic [clock_gen_pkg::PIN_COUNT-1:0] pin_s2_r;
  logic [clock_gen_pkg::PIN_COUNT-1:0] pin_d_r;
  logic [clock_gen_pkg::PIN_COUNT-1:0] rise;

  assign pins = {untrack_tol_out_pin, track_tol_in_pin, unlock_tol_out_pin,
                 lock_tol_in_pin, monitor_fail_pin, synth_clk_pin, osc_clk_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r  <= '0;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  assign rise = pin_s2_r & ~pin_d_r;

  logic osc_rise;
  logic synth_rise;
  assign osc_rise   = rise[clock_gen_pkg::PIN_OSC];
  assign synth_rise = rise[clock_gen_pkg::PIN_SYNTH];

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == clock_gen_pkg::ADDR_WDOG_CTRL) || (a == clock_gen_pkg::ADDR_WDOG_KEY) ||
           (a == clock_gen_pkg::ADDR_SYNTH_CFG) || (a == clock_gen_pkg::ADDR_CLK_CTRL) ||
           (a == clock_gen_pkg::ADDR_CLK_FLAG);
  endfunction

  logic wr_acc;
  logic rd_setup;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok(paddr);

  logic wd_ctrl_wr;
  logic wd_key_wr;
  logic cfg_wr;
  logic ctrl_wr;
  logic flag_wr;
  assign wd_ctrl_wr = wr_acc & (paddr == clock_gen_pkg::ADDR_WDOG_CTRL);
  assign wd_key_wr  = wr_acc & (paddr == clock_gen_pkg::ADDR_WDOG_KEY);
  assign cfg_wr     = wr_acc & (paddr == clock_gen_pkg::ADDR_SYNTH_CFG);
  assign ctrl_wr    = wr_acc & (paddr == clock_gen_pkg::ADDR_CLK_CTRL);
  assign flag_wr    = wr_acc & (paddr == clock_gen_pkg::ADDR_CLK_FLAG);

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [2:0]               wd_rate_r;
  logic                     wd_win_r;
  logic [3:0]               reference_divider_field_r;
  logic [5:0]               multiplier_field_r;
  clock_gen_pkg::clk_ctrl_t ctrl_r;
  logic                     scm_r;
  logic                     scm_enter;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_rate_r <= 3'h0;
      wd_win_r  <= 1'b0;
    end else if (wd_ctrl_wr) begin
      wd_rate_r <= pwdata[clock_gen_pkg::WD_RATE_LSB +: 3];
      wd_win_r  <= pwdata[clock_gen_pkg::WD_WIN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_divider_field_r <= 4'h0;
      multiplier_field_r  <= 6'h00;
    end else if (cfg_wr) begin
      reference_divider_field_r <= pwdata[clock_gen_pkg::REFERENCE_DIVIDER_FIELD_LSB +: 4];
      multiplier_field_r  <= pwdata[clock_gen_pkg::MULTIPLIER_FIELD_LSB +: 6];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= clock_gen_pkg::CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= clock_gen_pkg::clk_ctrl_t'(pwdata[6:0]);
      end
      if (scm_enter) begin
        ctrl_r.synth_clock_select <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, counted in oscillator cycles
  logic [24:0] wd_cnt_r;
  logic        wd_armed_r;
  logic        wd_on;
  logic [4:0]  wd_e;
  logic [24:0] wd_period;
  logic        wd_open;
  logic        key_first;
  logic        key_second;
  logic        wd_bad;
  logic        wd_restart;
  logic        wd_timeout;

  assign wd_on      = wd_rate_r != 3'h0;
  assign wd_e       = clock_gen_pkg::wd_exp(wd_rate_r) - WD_EXP_CUT;
  assign wd_period  = 25'h1 << wd_e;
  assign wd_open    = ~wd_win_r | (wd_cnt_r >= (wd_period - (wd_period >> 2)));
  assign key_first  = pwdata[7:0] == clock_gen_pkg::KEY_FIRST;
  assign key_second = pwdata[7:0] == clock_gen_pkg::KEY_SECOND;
  assign wd_bad     = wd_on & wd_key_wr & (~(key_first | key_second) | ~wd_open);
  assign wd_restart = wd_on & wd_key_wr & wd_open & key_second & wd_armed_r;
  assign wd_timeout = wd_on & osc_rise & (wd_cnt_r == (wd_period - 25'h1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= 25'h0;
    end else if (!wd_on || wd_ctrl_wr || wd_restart || wd_bad || wd_timeout) begin
      wd_cnt_r <= 25'h0;
    end else if (osc_rise) begin
      wd_cnt_r <= wd_cnt_r + 25'h1;
    end
  end

  // a second key without the first is tolerated but restarts nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_armed_r <= 1'b0;
    end else if (!wd_on || wd_ctrl_wr || wd_bad || wd_timeout || wd_restart) begin
      wd_armed_r <= 1'b0;
    end else if (wd_key_wr && key_first) begin
      wd_armed_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wd_bad | wd_timeout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference and feedback dividers
  logic [3:0] ref_cnt_r;
  logic [6:0] fb_cnt_r;
  logic [6:0] fb_last;
  assign fb_last = {multiplier_field_r, 1'b1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_r <= 4'h0;
      ref_tick  <= 1'b0;
    end else begin
      ref_tick <= 1'b0;
      if (osc_rise) begin
        if (ref_cnt_r >= reference_divider_field_r) begin
          ref_cnt_r <= 4'h0;
          ref_tick  <= 1'b1;
        end else begin
          ref_cnt_r <= ref_cnt_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cnt_r <= 7'h00;
      fb_tick  <= 1'b0;
    end else begin
      fb_tick <= 1'b0;
      if (synth_rise && synth_power_on) begin
        if (fb_cnt_r >= fb_last) begin
          fb_cnt_r <= 7'h00;
          fb_tick  <= 1'b1;
        end else begin
          fb_cnt_r <= fb_cnt_r + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lock and tracking status
  logic active_sel_r;
  logic lock_r;
  logic lock_nxt;
  logic track_r;
  logic lock_flag_r;

  assign synth_power_on = ctrl_r.synth_enable | active_sel_r | scm_r;

  always_comb begin
    lock_nxt = lock_r;
    if (!ctrl_r.auto_mode || !synth_power_on) begin
      lock_nxt = 1'b0;
    end else if (pin_s2_r[clock_gen_pkg::PIN_LOCK_IN]) begin
      lock_nxt = 1'b1;
    end else if (pin_s2_r[clock_gen_pkg::PIN_UNL_OUT]) begin
      lock_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_r <= 1'b0;
    end else if (!ctrl_r.auto_mode) begin
      track_r <= ~ctrl_r.acq;
    end else if (!synth_power_on) begin
      track_r <= 1'b0;
    end else if (pin_s2_r[clock_gen_pkg::PIN_TRK_IN]) begin
      track_r <= 1'b1;
    end else if (pin_s2_r[clock_gen_pkg::PIN_UNT_OUT]) begin
      track_r <= 1'b0;
    end
  end

  assign filter_acquire = ~track_r;

  clock_gen_pkg::clk_flag_t flag_wd;
  assign flag_wd = clock_gen_pkg::clk_flag_t'(pwdata[3:0]);

  // set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_flag_r <= 1'b0;
    end else if (lock_nxt != lock_r) begin
      lock_flag_r <= 1'b1;
    end else if (flag_wr && flag_wd.lock_irq_flag) begin
      lock_flag_r <= 1'b0;
    end
  end

  assign lock_irq = lock_flag_r & ctrl_r.lock_interrupt_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // clock monitor and self-clock mode
  logic fail;
  assign monitor_enable_out = ctrl_r.monitor_enable;
  assign fail      = ctrl_r.monitor_enable & pin_s2_r[clock_gen_pkg::PIN_FAIL];
  assign scm_enter = fail & ctrl_r.self_clock_enable & ~scm_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scm_r <= 1'b0;
    end else if (scm_enter) begin
      scm_r <= 1'b1;
    end else if (!fail) begin
      scm_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_reset <= 1'b0;
    end else begin
      monitor_reset <= ctrl_r.monitor_enable & rise[clock_gen_pkg::PIN_FAIL] &
                       ~ctrl_r.self_clock_enable;
    end
  end

  assign self_clock_min_freq_req = scm_r;

  ////////////////////////////////////////////////////////////////////////////////
  // clock source switch
  clock_gen_pkg::sw_state_t sw_state_r;
  logic [2:0]               sw_cnt_r;
  logic                     sw_target_r;
  logic                     sel_req;
  assign sel_req = ctrl_r.synth_clock_select & ~scm_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state_r   <= clock_gen_pkg::SW_IDLE;
      sw_cnt_r     <= 3'h0;
      sw_target_r  <= 1'b0;
      active_sel_r <= 1'b0;
    end else begin
      unique case (sw_state_r)
        clock_gen_pkg::SW_IDLE: begin
          if (sel_req != active_sel_r) begin
            sw_state_r  <= clock_gen_pkg::SW_OSC;
            sw_target_r <= sel_req;
            sw_cnt_r    <= 3'h0;
          end
        end
        clock_gen_pkg::SW_OSC: begin
          if (osc_rise) begin
            if (sw_cnt_r == clock_gen_pkg::SW_EDGES - 3'h1) begin
              sw_state_r <= clock_gen_pkg::SW_SYN;
              sw_cnt_r   <= 3'h0;
            end else begin
              sw_cnt_r <= sw_cnt_r + 3'h1;
            end
          end
        end
        clock_gen_pkg::SW_SYN: begin
          if (synth_rise) begin
            if (sw_cnt_r == clock_gen_pkg::SW_EDGES - 3'h1) begin
              sw_state_r   <= clock_gen_pkg::SW_IDLE;
              active_sel_r <= sw_target_r;
              sw_cnt_r     <= 3'h0;
            end else begin
              sw_cnt_r <= sw_cnt_r + 3'h1;
            end
          end
        end
        default: begin
          sw_state_r <= clock_gen_pkg::SW_IDLE;
        end
      endcase
    end
  end

  assign cpu_halt = sw_state_r != clock_gen_pkg::SW_IDLE;

  ////////////////////////////////////////////////////////////////////////////////
  // core and bus clocks
  logic use_synth;
  logic src_level;
  logic src_rise;
  assign use_synth = active_sel_r | scm_r;
  assign src_level = use_synth ? pin_s2_r[clock_gen_pkg::PIN_SYNTH] : pin_s2_r[clock_gen_pkg::PIN_OSC];
  assign src_rise  = use_synth ? synth_rise : osc_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clk <= 1'b0;
    end else if (!cpu_halt) begin
      core_clk <= src_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_clk <= 1'b0;
    end else if (!cpu_halt && src_rise) begin
      bus_clk <= ~bus_clk;
    end
  end

  assign external_bus_clock_out = bus_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle
  clock_gen_pkg::clk_flag_t flags;
  assign flags = '{lock_irq_flag: lock_flag_r, self_clock_mode: scm_r,
                   track: track_r, lock: lock_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        clock_gen_pkg::ADDR_WDOG_CTRL: prdata <= {24'h00_0000, wd_win_r, 4'h0, wd_rate_r};
        clock_gen_pkg::ADDR_SYNTH_CFG: prdata <= {18'h0_0000, multiplier_field_r, 4'h0, reference_divider_field_r};
        clock_gen_pkg::ADDR_CLK_CTRL:  prdata <= {25'h000_0000, ctrl_r};
        clock_gen_pkg::ADDR_CLK_FLAG:  prdata <= {28'h000_0000, flags};
        default:                       prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// [testbench/clock_gen_watchdog_arm_chk.sv]
// port assertions of the clock generator and watchdog
`timescale 1ns/100ps
module clock_gen_chk (
  input logic        pclk,                    // clock
  input logic        presetn,                 // reset, active low
  input logic        psel,                    // apb select
  input logic        penable,                 // apb enable
  input logic        pwrite,                  // apb direction
  input logic [7:0]  paddr,                   // apb address
  input logic [31:0] pwdata,                  // apb write data
  input logic [31:0] prdata,                  // apb read data
  input logic        cpu_halt,                // switch in progress
  input logic        bus_clk,                 // bus clock
  input logic        core_clk,                // core clock
  input logic        external_bus_clock_out,  // bus clock pin
  input logic        watchdog_reset,          // watchdog reset pulse
  input logic        monitor_reset,           // monitor reset pulse
  input logic        monitor_enable_out       // monitor on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] rate_r;
  logic       win_r;
  logic       kw;
  logic       good;
  assign kw   = psel && penable && pwrite && paddr == clock_gen_pkg::ADDR_WDOG_KEY;
  assign good = pwdata[7:0] == clock_gen_pkg::KEY_FIRST || pwdata[7:0] == clock_gen_pkg::KEY_SECOND;
  ////////////////////////////////////////////////////////////////////////
  // shadow of the watchdog control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_r <= 3'h0;
      win_r  <= 1'b0;
    end else if (psel && penable && pwrite && paddr == clock_gen_pkg::ADDR_WDOG_CTRL) begin
      rate_r <= pwdata[2:0];
      win_r  <= pwdata[7];
    end
  end
  a_key_reads_zero: assert property (
    psel && !penable && !pwrite && paddr == clock_gen_pkg::ADDR_WDOG_KEY |=> prdata == 32'h0)
    else $error("key register read not zero");
  a_wd_off_quiet: assert property (
    rate_r == 3'h0 && $past(rate_r) == 3'h0 |-> !watchdog_reset)
    else $error("watchdog reset while disabled");
  a_bad_key_reset: assert property (
    kw && rate_r != 3'h0 && !good |=> watchdog_reset)
    else $error("bad key without reset");
  a_good_key_quiet: assert property (
    kw && !win_r && good |=> !watchdog_reset)
    else $error("key write caused reset");
  a_switch_bound: assert property (
    $rose(cpu_halt) |-> ##[1:300] !cpu_halt)
    else $error("source switch too long");
  a_clocks_frozen: assert property (
    cpu_halt && $past(cpu_halt) |-> $stable(bus_clk) && $stable(core_clk))
    else $error("clock moved during switch");
  a_ext_clk_pin: assert property (
    external_bus_clock_out == bus_clk)
    else $error("external clock differs from bus clock");
  a_mon_off_quiet: assert property (
    !monitor_enable_out && !$past(monitor_enable_out) |-> !monitor_reset)
    else $error("monitor reset while monitor off");
endmodule

// [testbench/tb_clock_gen_watchdog_arm.sv]
// self-checking bench of the clock generator and watchdog
`timescale 1ns/100ps
module tb_clock_gen_watchdog_arm;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        osc_clk_pin = 1'b0, synth_clk_pin = 1'b0, monitor_fail_pin = 1'b0;
  logic        lock_tol_in_pin = 1'b0, unlock_tol_out_pin = 1'b0;
  logic        track_tol_in_pin = 1'b0, untrack_tol_out_pin = 1'b0;
  logic        pready, pslverr, ref_tick, fb_tick, synth_power_on, filter_acquire, er;
  logic        self_clock_min_freq_req, monitor_enable_out, core_clk, bus_clk;
  logic        external_bus_clock_out, cpu_halt, lock_irq, watchdog_reset, monitor_reset;
  int          failures = 0, tests_run = 0, wd_n = 0, mr_n = 0, oc = 0, sc = 0, g, n;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  row_t rows[3] = '{'{clock_gen_pkg::ADDR_SYNTH_CFG, 32'hFFFF_FFFF, 32'h0000_3F0F, 1'b0},
                    '{clock_gen_pkg::ADDR_WDOG_KEY, 32'h0000_0012, 32'h0, 1'b0},
                    '{8'h20, 32'h1234_5678, 32'h0, 1'b1}};
  clock_gen_watchdog_arm #(.WD_EXP_CUT(5'h0A)) dut_u (.*);
  always #2 pclk = ~pclk;
  // oscillator 8 pclk period, synthesizer 6 pclk period
  always @(posedge pclk) begin
    oc <= (oc == 3) ? 0 : oc + 1;
    sc <= (sc == 2) ? 0 : sc + 1;
    if (oc == 3) osc_clk_pin <= ~osc_clk_pin;
    if (sc == 2) synth_clk_pin <= ~synth_clk_pin;
    wd_n <= wd_n + (watchdog_reset === 1'b1);
    mr_n <= mr_n + (monitor_reset === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] q);
    apb(a, 1'b0, 32'h0);
    chk(rd, q);
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? ref_tick : k == 1 ? fb_tick : k == 2 ? bus_clk : core_clk;
  endfunction
  // cycles between two rising values of the picked output
  task automatic gap(input int k);
    logic p;
    repeat (2) begin
      g = 0;
      do begin
        p = pick(k);
        @(posedge pclk);
        g++;
      end while (!(pick(k) === 1'b1 && p !== 1'b1) && g < 400);
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  initial begin
    repeat (10000) @(posedge pclk);
    failures++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    chk(filter_acquire, 1);
    chk(monitor_enable_out, 1);
    rdc(clock_gen_pkg::ADDR_CLK_CTRL, 32'h0000_006C);
    rdc(clock_gen_pkg::ADDR_CLK_FLAG, 32'h0);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      rdc(rows[i].a, rows[i].q);
      chk(er, rows[i].e);
    end
    apb(clock_gen_pkg::ADDR_WDOG_CTRL, 1'b1, 32'h1);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'h55);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'h55);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'hAA);
    repeat (60) @(posedge pclk);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'hAA);
    chk(wd_n, 0);
    n = 0;
    while (watchdog_reset !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 50 && n <= 80, 1);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'h5A);
    repeat (3) @(posedge pclk);
    chk(wd_n, 2);
    apb(clock_gen_pkg::ADDR_WDOG_CTRL, 1'b1, 32'h81);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'h55);
    repeat (3) @(posedge pclk);
    chk(wd_n, 3);
    apb(clock_gen_pkg::ADDR_WDOG_CTRL, 1'b1, 32'h81);
    repeat (104) @(posedge pclk);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'h55);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'hAA);
    apb(clock_gen_pkg::ADDR_WDOG_CTRL, 1'b1, 32'h0);
    apb(clock_gen_pkg::ADDR_WDOG_KEY, 1'b1, 32'h12);
    repeat (3) @(posedge pclk);
    chk(wd_n, 3);
    apb(clock_gen_pkg::ADDR_SYNTH_CFG, 1'b1, 32'h0000_0202);
    apb(clock_gen_pkg::ADDR_CLK_CTRL, 1'b1, 32'h0000_006E);
    foreach (rows[k]) begin
      gap(k);
      chk(g, k == 0 ? 24 : k == 1 ? 36 : 16);
    end
    gap(3);
    chk(g, 8);
    apb(clock_gen_pkg::ADDR_CLK_CTRL, 1'b1, 32'h0000_007E);
    lock_tol_in_pin <= 1'b1;
    track_tol_in_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc(clock_gen_pkg::ADDR_CLK_FLAG, 32'h0000_000B);
    chk({lock_irq, filter_acquire}, 2'b10);
    apb(clock_gen_pkg::ADDR_CLK_FLAG, 1'b1, 32'h8);
    // the clear lands at the access edge, visible one cycle later
    @(posedge pclk);
    chk(lock_irq, 0);
    {lock_tol_in_pin, unlock_tol_out_pin, track_tol_in_pin, untrack_tol_out_pin} <= 4'h5;
    repeat (8) @(posedge pclk);
    rdc(clock_gen_pkg::ADDR_CLK_FLAG, 32'h0000_0008);
    chk({lock_irq, filter_acquire}, 2'b11);
    apb(clock_gen_pkg::ADDR_CLK_CTRL, 1'b1, 32'h0000_006A);
    repeat (2) @(posedge pclk);
    chk(filter_acquire, 1);
    apb(clock_gen_pkg::ADDR_CLK_CTRL, 1'b1, 32'h0000_0062);
    // track follows the control register one cycle after the write
    repeat (2) @(posedge pclk);
    chk(filter_acquire, 0);
    apb(clock_gen_pkg::ADDR_CLK_CTRL, 1'b1, 32'h0000_0063);
    n = 0;
    while ((cpu_halt !== 1'b0 && n < 200) || n < 2) begin
      @(posedge pclk);
      n++;
    end
    chk(n > 2 && n < 90, 1);
    gap(2);
    chk(g, 12);
    gap(3);
    chk(g, 6);
    apb(clock_gen_pkg::ADDR_CLK_CTRL, 1'b1, 32'h0000_0061);
    repeat (2) @(posedge pclk);
    chk(synth_power_on, 1);
    do_reset();
    monitor_fail_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(self_clock_min_freq_req, 1);
    rdc(clock_gen_pkg::ADDR_CLK_FLAG, 32'h0000_0004);
    monitor_fail_pin <= 1'b0;
    apb(clock_gen_pkg::ADDR_CLK_CTRL, 1'b1, 32'h0000_0040);
    monitor_fail_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(mr_n, 1);
    monitor_fail_pin <= 1'b0;
    apb(clock_gen_pkg::ADDR_CLK_CTRL, 1'b1, 32'h0);
    monitor_fail_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({mr_n[1:0], monitor_enable_out}, 3'b010);
    print_verdict();
  end
endmodule
bind clock_gen_watchdog_arm clock_gen_chk chk_u (.*);
